// [verilog/mdcc_pkg.sv]
`default_nettype none
// ==========================================
// shared constants of the config bank
package mdcc_pkg;
    typedef logic [7:0] mdcc_byte_t;
    typedef logic [1:0] mdcc_code_t;

    localparam int APB_AW = 9;
    localparam int NSLOT = 13;
    localparam int NUM_CH = 8;
    localparam int LOW_CH = 4;
    localparam int GRP_CH = 4;

    // register indices; byte address is four times the index
    localparam logic [6:0] IDX_STBY = 7'h00;
    localparam logic [6:0] IDX_MODEA = 7'h01;
    localparam logic [6:0] IDX_MODEB = 7'h02;
    localparam logic [6:0] IDX_GRP = 7'h03;
    localparam logic [6:0] IDX_PWR = 7'h04;
    localparam logic [6:0] IDX_GEN = 7'h05;
    localparam logic [6:0] IDX_DATA = 7'h06;
    localparam logic [6:0] IDX_IFC = 7'h07;
    localparam logic [6:0] IDX_BIST = 7'h08;
    localparam logic [6:0] IDX_STAT = 7'h09;
    localparam logic [6:0] IDX_REV = 7'h0A;
    localparam logic [6:0] IDX_DLY = 7'h58;
    localparam logic [6:0] IDX_CHOP = 7'h59;

    // slot order in the storage array
    localparam int S_STBY = 0;
    localparam int S_MODEA = 1;
    localparam int S_MODEB = 2;
    localparam int S_GRP = 3;
    localparam int S_PWR = 4;
    localparam int S_GEN = 5;
    localparam int S_DATA = 6;
    localparam int S_IFC = 7;
    localparam int S_BIST = 8;
    localparam int S_STAT = 9;
    localparam int S_REV = 10;
    localparam int S_DLY = 11;
    localparam int S_CHOP = 12;

    localparam logic [6:0] SLOT_IDX [NSLOT] = '{
        IDX_STBY, IDX_MODEA, IDX_MODEB, IDX_GRP, IDX_PWR, IDX_GEN,
        IDX_DATA, IDX_IFC, IDX_BIST, IDX_STAT, IDX_REV, IDX_DLY, IDX_CHOP};
    localparam mdcc_byte_t SLOT_RST [NSLOT] = '{
        8'h00, 8'h0D, 8'h0D, 8'h00, 8'h00, 8'h08,
        8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h0A};
    // implemented bits; unused bits read zero
    localparam mdcc_byte_t SLOT_MASK [NSLOT] = '{
        8'h0F, 8'h0F, 8'h0F, 8'h3F, 8'hBB, 8'h7B,
        8'h93, 8'h0F, 8'h01, 8'h0F, 8'hFF, 8'h0F, 8'h0F};
    localparam logic [NSLOT-1:0] SLOT_RO = 13'h0600;

    localparam int DLY_SEL_LSB = 2;
    localparam int CHOPA_LSB = 2;
    localparam int CHOPB_LSB = 0;
    localparam int BIST_GO_BIT = 0;
    localparam mdcc_byte_t DLY_RST = 8'h02;

    localparam mdcc_code_t DLY_NONE = 2'h0;
    localparam mdcc_code_t DLY_LOW = 2'h1;
    localparam mdcc_code_t DLY_HIGH = 2'h2;
    localparam mdcc_code_t DLY_ALL = 2'h3;
    localparam mdcc_code_t CHOP_DIV8 = 2'h1;
    localparam mdcc_code_t CHOP_DIV32 = 2'h2;
    localparam logic [4:0] LIM_DIV8 = 5'h07;
    localparam logic [4:0] LIM_DIV32 = 5'h1F;

    // group bit of channel 0..3 in the assignment register
    localparam int GRP_POS [GRP_CH] = '{0, 1, 4, 5};
endpackage
`default_nettype wire

// [verilog/mdcc_cfg_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// decoded settings passed to each channel slice
interface mdcc_cfg_if;
    logic [1:0] delay_sel;
    logic [1:0] chop_a;
    logic [1:0] chop_b;
    modport src (output delay_sel, output chop_a, output chop_b);
    modport dst (input delay_sel, input chop_a, input chop_b);
endinterface
`default_nettype wire

// [verilog/mdcc_chan.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// one channel: delayed clock enable and chop rate
module mdcc_chan #(
    parameter int CH = 0
) (
    input wire logic pclk,
    input wire logic presetn,
    mdcc_cfg_if.dst cfg,
    input wire logic grp_b,
    output logic delay_en,
    output logic in_grp_b,
    output logic [1:0] chop_rate
);
    logic dly_d;

    // half select: low code hits channels below four only
    assign dly_d = (cfg.delay_sel == mdcc_pkg::DLY_ALL) ||
                   (cfg.delay_sel == mdcc_pkg::DLY_LOW && CH < mdcc_pkg::LOW_CH) ||
                   (cfg.delay_sel == mdcc_pkg::DLY_HIGH && CH >= mdcc_pkg::LOW_CH);

    // outputs are flopped to keep them glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delay_en <= 1'b0;
            in_grp_b <= 1'b0;
            chop_rate <= mdcc_pkg::CHOP_DIV32;
        end else begin
            delay_en <= dly_d; // RULE1 RULE2
            in_grp_b <= grp_b; // RULE6
            chop_rate <= grp_b ? cfg.chop_b : cfg.chop_a; // RULE6
        end
    end

    chan_grp_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
        1'b1 |=> chop_rate == (in_grp_b ? $past(cfg.chop_b) : $past(cfg.chop_a)))
        else $error("channel chop rate does not follow its group");
endmodule // mdcc_chan
`default_nettype wire

// [verilog/mdcc_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1: delay code 01 delays channels 0-3 only, 10 delays channels 4-7 only.
// RULE2: delay code 00 delays none, 11 delays all; resets to 00.
// RULE3: software writes 2 into delay reserved bits; reset value 0x02.
// RULE4: first group chop field bits 3:2; 01 is mod/8, 10 is mod/32.
// RULE5: second group chop bits 1:0 same coding; chop register resets 0x0A.
// RULE6: each channel takes its group from the channel assignment register; only channels 0-3 have a bit here, 4-7 stay in group a.
// RULE7: read-only writes ignored; unused bits read as zero.
module mdcc_top #(
    parameter logic [7:0] REV_CODE = 8'h5A // arbitrary value
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mdcc_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mod_tick,
    input wire logic chip_error,
    input wire logic no_clock_error,
    input wire logic memory_selftest_passed,
    input wire logic memory_selftest_active,
    output logic [3:0] standby_mask,
    output logic [7:0] group_a_filter_decimation,
    output logic [7:0] group_b_filter_decimation,
    output logic [7:0] power_sleep_clock_divider,
    output logic [7:0] general_configuration,
    output logic [7:0] data_sync_control,
    output logic [7:0] serial_output_configuration,
    output logic memory_selftest_launch,
    output logic [mdcc_pkg::NUM_CH-1:0] ch_delay_en,
    output logic [mdcc_pkg::NUM_CH-1:0] ch_in_grp_b,
    output logic [2*mdcc_pkg::NUM_CH-1:0] ch_chop_rate,
    output logic chop_tick_a,
    output logic chop_tick_b
);
    // ==========================================
    // apb decode

    mdcc_pkg::mdcc_byte_t regs_q [mdcc_pkg::NSLOT];
    mdcc_pkg::mdcc_byte_t rval [mdcc_pkg::NSLOT];
    logic [mdcc_pkg::NSLOT-1:0] hit;
    logic [6:0] word_idx;
    logic aligned;
    logic mapped;
    logic setup_ph;
    logic access_ph;
    logic wr_en;
    mdcc_pkg::mdcc_byte_t rd_byte;
    logic [31:0] prdata_d;

    assign word_idx = paddr[mdcc_pkg::APB_AW-1:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign mapped = aligned && (|hit);
    // zero wait states: every access ends in its first access cycle
    assign pready = 1'b1;
    assign pslverr = access_ph && !mapped;
    assign wr_en = access_ph && pwrite && mapped;

    // one comparator per slot against its printed index
    genvar gs;
    generate
        for (gs = 0; gs < mdcc_pkg::NSLOT; gs++) begin : g_hit
            assign hit[gs] = aligned && (word_idx == mdcc_pkg::SLOT_IDX[gs]);
        end
    endgenerate

    // ==========================================
    // storage

    // read-only slots never take a write, unused bits are masked off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < mdcc_pkg::NSLOT; i++) begin
                regs_q[i] <= mdcc_pkg::SLOT_RST[i]; // RULE2 RULE3 RULE5
            end
        end else begin
            for (int i = 0; i < mdcc_pkg::NSLOT; i++) begin
                if (wr_en && hit[i] && !mdcc_pkg::SLOT_RO[i]) begin // RULE7
                    regs_q[i] <= pwdata[7:0] & mdcc_pkg::SLOT_MASK[i];
                end
            end
        end
    end

    // ==========================================
    // read path

    // status comes from live inputs and revision from REV_CODE, not from storage
    mdcc_pkg::mdcc_byte_t stat_byte;
    assign stat_byte = {4'h0, chip_error, no_clock_error,
                        memory_selftest_passed, memory_selftest_active};

    generate
        for (gs = 0; gs < mdcc_pkg::NSLOT; gs++) begin : g_rval
            if (gs == mdcc_pkg::S_STAT) begin : g_st
                assign rval[gs] = stat_byte & mdcc_pkg::SLOT_MASK[gs];
            end else if (gs == mdcc_pkg::S_REV) begin : g_rv
                assign rval[gs] = REV_CODE;
            end else begin : g_rw
                assign rval[gs] = regs_q[gs] & mdcc_pkg::SLOT_MASK[gs]; // RULE7
            end
        end
    endgenerate

    // one-hot select; an unmapped address reads zero
    always_comb begin
        rd_byte = 8'h00;
        for (int i = 0; i < mdcc_pkg::NSLOT; i++) begin
            if (hit[i]) begin
                rd_byte = rd_byte | rval[i];
            end
        end
    end

    assign prdata_d = {24'h000000, rd_byte};

    // sampled in the setup cycle so prdata is a flop during access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_ph && !pwrite) begin
            prdata <= prdata_d;
        end
    end

    // ==========================================
    // configuration outputs

    assign standby_mask = regs_q[mdcc_pkg::S_STBY][3:0];
    assign group_a_filter_decimation = regs_q[mdcc_pkg::S_MODEA];
    assign group_b_filter_decimation = regs_q[mdcc_pkg::S_MODEB];
    assign power_sleep_clock_divider = regs_q[mdcc_pkg::S_PWR];
    assign general_configuration = regs_q[mdcc_pkg::S_GEN];
    assign data_sync_control = regs_q[mdcc_pkg::S_DATA];
    assign serial_output_configuration = regs_q[mdcc_pkg::S_IFC];
    assign memory_selftest_launch = regs_q[mdcc_pkg::S_BIST][mdcc_pkg::BIST_GO_BIT];

    // ==========================================
    // channel slices

    mdcc_cfg_if cfg ();
    mdcc_pkg::mdcc_byte_t dly_reg;
    mdcc_pkg::mdcc_byte_t chop_reg;
    mdcc_pkg::mdcc_byte_t grp_reg;
    logic [mdcc_pkg::NUM_CH-1:0] ch_grp_b;

    assign dly_reg = regs_q[mdcc_pkg::S_DLY];
    assign chop_reg = regs_q[mdcc_pkg::S_CHOP];
    assign grp_reg = regs_q[mdcc_pkg::S_GRP];
    assign cfg.delay_sel = dly_reg[mdcc_pkg::DLY_SEL_LSB +: 2]; // RULE1
    assign cfg.chop_a = chop_reg[mdcc_pkg::CHOPA_LSB +: 2]; // RULE4
    assign cfg.chop_b = chop_reg[mdcc_pkg::CHOPB_LSB +: 2]; // RULE5

    genvar gc;
    generate
        for (gc = 0; gc < mdcc_pkg::NUM_CH; gc++) begin : g_ch
            // upper channels have no membership bit and stay in group a
            if (gc < mdcc_pkg::GRP_CH) begin : g_m
                assign ch_grp_b[gc] = grp_reg[mdcc_pkg::GRP_POS[gc]]; // RULE6
            end else begin : g_n
                assign ch_grp_b[gc] = 1'b0;
            end
            mdcc_chan #(.CH(gc)) u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .cfg(cfg.dst),
                .grp_b(ch_grp_b[gc]),
                .delay_en(ch_delay_en[gc]),
                .in_grp_b(ch_in_grp_b[gc]),
                .chop_rate(ch_chop_rate[2*gc +: 2])
            );
        end
    endgenerate

    // ==========================================
    // chop rate dividers on the modulator tick

    logic [4:0] cnt_q [2];
    logic [1:0] tick_q;
    logic [1:0] code_w [2];
    logic [4:0] lim_w [2];
    logic [1:0] run_w;

    assign code_w[0] = cfg.chop_a;
    assign code_w[1] = cfg.chop_b;

    // undefined codes stop the divider rather than guess a rate
    genvar gg;
    generate
        for (gg = 0; gg < 2; gg++) begin : g_div
            assign run_w[gg] = (code_w[gg] == mdcc_pkg::CHOP_DIV8) ||
                               (code_w[gg] == mdcc_pkg::CHOP_DIV32);
            assign lim_w[gg] = (code_w[gg] == mdcc_pkg::CHOP_DIV8) ?
                               mdcc_pkg::LIM_DIV8 : mdcc_pkg::LIM_DIV32; // RULE4 RULE5
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_q[gg] <= 5'h00;
                    tick_q[gg] <= 1'b0;
                end else if (!run_w[gg]) begin
                    cnt_q[gg] <= 5'h00;
                    tick_q[gg] <= 1'b0;
                end else if (mod_tick) begin
                    // a shorter limit may leave cnt above it: wrap there too
                    cnt_q[gg] <= (cnt_q[gg] >= lim_w[gg]) ? 5'h00 : cnt_q[gg] + 5'h01;
                    tick_q[gg] <= (cnt_q[gg] >= lim_w[gg]);
                end else begin
                    tick_q[gg] <= 1'b0;
                end
            end
        end
    endgenerate

    assign chop_tick_a = tick_q[0];
    assign chop_tick_b = tick_q[1];

    // ==========================================
    // checks

    sequence rd_acc(logic [6:0] idx);
        psel && penable && !pwrite && aligned && word_idx == idx;
    endsequence

    sequence wr_acc(logic [6:0] idx);
        psel && penable && pwrite && aligned && word_idx == idx;
    endsequence

    dly_low_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        cfg.delay_sel == mdcc_pkg::DLY_LOW |=> ch_delay_en == 8'h0F)
        else $error("low half delay select wrong");

    dly_high_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        cfg.delay_sel == mdcc_pkg::DLY_HIGH |=> ch_delay_en == 8'hF0)
        else $error("high half delay select wrong");

    dly_none_all_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        (cfg.delay_sel == mdcc_pkg::DLY_NONE |=> ch_delay_en == 8'h00) and
        (cfg.delay_sel == mdcc_pkg::DLY_ALL |=> ch_delay_en == 8'hFF))
        else $error("none or all delay select wrong");

    dly_reset_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        !$past(presetn) |-> dly_reg == mdcc_pkg::DLY_RST &&
            chop_reg == mdcc_pkg::SLOT_RST[mdcc_pkg::S_CHOP])
        else $error("delay or chop reset value wrong");

    chop_div8_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        cfg.chop_a == mdcc_pkg::CHOP_DIV8 && mod_tick && cnt_q[0] == mdcc_pkg::LIM_DIV8
        |=> chop_tick_a ##1 !chop_tick_a)
        else $error("group a divide by 8 tick missing");

    chop_div32_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        (cfg.chop_b == mdcc_pkg::CHOP_DIV32 && mod_tick && cnt_q[1] == mdcc_pkg::LIM_DIV8
         |=> !chop_tick_b) and
        (cfg.chop_b == mdcc_pkg::CHOP_DIV32 && mod_tick && cnt_q[1] == mdcc_pkg::LIM_DIV32
         |=> chop_tick_b))
        else $error("group b divide by 32 timing wrong");

    grp_member_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
        1'b1 |=> ch_in_grp_b[3:0] == {$past(grp_reg[5]), $past(grp_reg[4]),
                                      $past(grp_reg[1]), $past(grp_reg[0])})
        else $error("channel group membership wrong");

    ro_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        wr_acc(mdcc_pkg::IDX_STAT) or wr_acc(mdcc_pkg::IDX_REV)
        |=> regs_q[mdcc_pkg::S_STAT] == $past(regs_q[mdcc_pkg::S_STAT]) &&
            regs_q[mdcc_pkg::S_REV] == $past(regs_q[mdcc_pkg::S_REV]))
        else $error("read-only register changed by a write");

    rev_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        rd_acc(mdcc_pkg::IDX_REV) |-> prdata == {24'h000000, REV_CODE})
        else $error("revision read wrong");

    dly_rdback_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        wr_acc(mdcc_pkg::IDX_DLY) ##1 (setup_ph && !pwrite && hit[mdcc_pkg::S_DLY])
        ##1 rd_acc(mdcc_pkg::IDX_DLY)
        |-> prdata == {24'h000000, 4'h0, $past(pwdata[3:0], 2)})
        else $error("delay register readback wrong");

    unmapped_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        access_ph && !mapped |-> pslverr && pready)
        else $error("unmapped access not flagged");

    // reads: upper bits and unmapped places always return zero
    rd_upper_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        access_ph && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");

    unmapped_rd_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        access_ph && !pwrite && !mapped |-> prdata == 32'h00000000)
        else $error("unmapped read data not zero");

    stat_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        rd_acc(mdcc_pkg::IDX_STAT) |-> prdata[7:4] == 4'h0)
        else $error("status unused bits not zero");

    // writes: masked storage, refused writes leave the settings alone
    ro_no_err_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        wr_acc(mdcc_pkg::IDX_STAT) or wr_acc(mdcc_pkg::IDX_REV) |-> !pslverr)
        else $error("read-only write flagged as error");

    wr_mask_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        wr_acc(mdcc_pkg::IDX_STBY) |=> regs_q[mdcc_pkg::S_STBY] ==
            ($past(pwdata[7:0]) & mdcc_pkg::SLOT_MASK[mdcc_pkg::S_STBY]))
        else $error("unused standby bits stored");

    bad_wr_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        access_ph && pwrite && !mapped |=> $stable(dly_reg) && $stable(chop_reg))
        else $error("unmapped write changed a setting");

    // dividers: a tick needs a mod_tick, undefined codes hold the counter at zero
    chop_a_div32_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        (cfg.chop_a == mdcc_pkg::CHOP_DIV32 && mod_tick && cnt_q[0] == mdcc_pkg::LIM_DIV8
         |=> !chop_tick_a) and
        (cfg.chop_a == mdcc_pkg::CHOP_DIV32 && mod_tick && cnt_q[0] == mdcc_pkg::LIM_DIV32
         |=> chop_tick_a))
        else $error("group a divide by 32 timing wrong");

    chop_b_div8_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        cfg.chop_b == mdcc_pkg::CHOP_DIV8 && mod_tick && cnt_q[1] == mdcc_pkg::LIM_DIV8
        |=> chop_tick_b ##1 !chop_tick_b)
        else $error("group b divide by 8 tick missing");

    chop_stop_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        !run_w[0] |=> !chop_tick_a && cnt_q[0] == 5'h00)
        else $error("group a divider runs on an undefined code");

    chop_stop_b_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        !run_w[1] |=> !chop_tick_b && cnt_q[1] == 5'h00)
        else $error("group b divider runs on an undefined code");

    tick_gap_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        !mod_tick |=> !chop_tick_a && !chop_tick_b)
        else $error("chop tick without a modulator tick");

    grp_upper_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
        1'b1 |-> ch_in_grp_b[mdcc_pkg::NUM_CH-1:mdcc_pkg::GRP_CH] == '0)
        else $error("upper channel left group a");
endmodule // mdcc_top
`default_nettype wire

// [verif/modulator_delay_chop_config_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// register bank bench: apb tasks and directed sequences
module modulator_delay_chop_config_tb_top;
    localparam logic [7:0] REV_TB = 8'h3C; // arbitrary value
    localparam logic [8:0] A_DLY = {mdcc_pkg::IDX_DLY, 2'b00};
    localparam logic [8:0] A_CHOP = {mdcc_pkg::IDX_CHOP, 2'b00};
    localparam logic [7:0] GRP_B_EXP = 8'h0D; // assignment 0x31 puts ch0, ch2, ch3 in group b
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [8:0] paddr = 9'h000;
    logic [31:0] pwdata = 32'h0;
    logic mod_tick = 1'b0;
    logic [3:0] stat_in = 4'h0;
    logic [31:0] prdata;
    logic pready, pslverr, launch, tick_a, tick_b;
    logic [3:0] standby_mask;
    logic [7:0] ch_delay_en, ch_in_grp_b;
    logic [15:0] ch_chop_rate, chop_exp;
    int err_total = 0;
    int tests_run = 0;
    int ticks_a, ticks_b;
    logic [31:0] rd_v;
    logic er_v;
    logic chained = 1'b0;
    wire [47:0] cfg_o;
    logic [7:0] rst_tab [13] = '{8'h00, 8'h0D, 8'h0D, 8'h00, 8'h00, 8'h08, 8'h80,
        8'h00, 8'h00, 8'h00, REV_TB, 8'h02, 8'h0A};
    logic [7:0] dly_exp [4] = '{8'h00, 8'h0F, 8'hF0, 8'hFF};
    logic [7:0] chop_tab [5] = '{8'h0A, 8'h06, 8'h09, 8'h0F, 8'h00};
    int ea_tab [5] = '{2, 8, 2, 0, 0};
    int eb_tab [5] = '{2, 2, 8, 0, 0};

    mdcc_top #(.REV_CODE(REV_TB)) i_mdcc_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mod_tick(mod_tick),
        .chip_error(stat_in[3]), .no_clock_error(stat_in[2]),
        .memory_selftest_passed(stat_in[1]), .memory_selftest_active(stat_in[0]),
        .standby_mask(standby_mask), .group_a_filter_decimation(cfg_o[7:0]),
        .group_b_filter_decimation(cfg_o[15:8]), .power_sleep_clock_divider(cfg_o[23:16]),
        .general_configuration(cfg_o[31:24]), .data_sync_control(cfg_o[39:32]),
        .serial_output_configuration(cfg_o[47:40]), .memory_selftest_launch(launch),
        .ch_delay_en(ch_delay_en), .ch_in_grp_b(ch_in_grp_b),
        .ch_chop_rate(ch_chop_rate), .chop_tick_a(tick_a), .chop_tick_b(tick_b));

    // 20 MHz clock
    initial begin
        forever #25 pclk = ~pclk;
    end

    // tick counters; deltas are compared so no clearing is needed
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ticks_a <= 0;
            ticks_b <= 0;
        end else begin
            ticks_a <= ticks_a + int'(tick_a === 1'b1);
            ticks_b <= ticks_b + int'(tick_b === 1'b1);
        end
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // one apb transfer; keep leaves psel high so the next setup follows at once
    task automatic apb(input logic wr, input logic [8:0] a, input logic [7:0] d,
                       input logic keep, output logic [31:0] rd, output logic er);
        int n;
        if (!chained) begin
            @(posedge pclk);
            psel <= 1'b1;
        end
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (pready !== 1'b1) begin
            err_total++;
            end_sim();
        end
        rd = prdata;
        er = pslverr;
        chained = keep;
        penable <= 1'b0;
        if (!keep) begin
            psel <= 1'b0;
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 1'b0, rd_v, er_v);
    endtask

    // read and compare data and error flag
    task automatic rd_chk(input logic [8:0] a, input logic [31:0] e, input logic e_er);
        apb(1'b0, a, 8'h00, 1'b0, rd_v, er_v);
        chk("prdata", rd_v, e);
        chk("pslverr", {31'h0, er_v}, {31'h0, e_er});
    endtask

    // let the register and the derived channel flop land
    task automatic settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge pclk);
            mod_tick <= 1'b1;
            @(posedge pclk);
            mod_tick <= 1'b0;
        end
        repeat (4) @(posedge pclk);
        #1;
    endtask

    // write a chop code, check per-channel rate and tick counts over 64 ticks
    task automatic chop_run(input logic [7:0] code, input int ea, input int eb);
        int sa, sb;
        wr(A_CHOP, code);
        settle();
        for (int c = 0; c < 8; c++) begin
            chop_exp[2*c +: 2] = GRP_B_EXP[c] ? code[1:0] : code[3:2];
        end
        chk("ch_chop_rate", {16'h0, ch_chop_rate}, {16'h0, chop_exp});
        sa = ticks_a;
        sb = ticks_b;
        pulses(64);
        chk("ticks_a", ticks_a - sa, ea);
        chk("ticks_b", ticks_b - sb, eb);
    endtask

    // ==========================================
    // main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("rst_delay_en", {24'h0, ch_delay_en}, 32'h0);
        chk("rst_chop", {16'h0, ch_chop_rate}, 32'h0000AAAA);
        for (int i = 0; i < 13; i++) begin
            rd_chk({mdcc_pkg::SLOT_IDX[i], 2'b00}, {24'h0, rst_tab[i]}, 1'b0);
        end
        // every delay code, reserved bits kept at two
        for (int c = 0; c < 4; c++) begin
            wr(A_DLY, {4'h0, c[1:0], 2'b10});
            settle();
            chk("delay_en", {24'h0, ch_delay_en}, {24'h0, dly_exp[c]});
            rd_chk(A_DLY, {28'h0, c[1:0], 2'b10}, 1'b0);
        end
        // group membership from the assignment register
        wr(9'h00C, 8'h31);
        settle();
        chk("in_grp_b", {24'h0, ch_in_grp_b}, {24'h0, GRP_B_EXP});
        for (int k = 0; k < 5; k++) begin
            chop_run(chop_tab[k], ea_tab[k], eb_tab[k]);
        end
        // unused bits drop, read-only places ignore writes
        wr(9'h000, 8'hFF);
        settle();
        chk("standby_mask", {28'h0, standby_mask}, 32'hF);
        rd_chk(9'h000, 32'h0F, 1'b0);
        // every other setting output keeps only its implemented bits
        for (int i = 1; i < 8; i++) begin
            if (i != 3) begin
                wr({i[6:0], 2'b00}, 8'hFF);
            end
        end
        settle();
        chk("cfg_lo", cfg_o[31:0], 32'h7BBB0F0F);
        chk("cfg_hi", {16'h0, cfg_o[47:32]}, 32'h00000F93);
        wr(9'h020, 8'hFF);
        settle();
        chk("selftest_launch", {31'h0, launch}, 32'h1);
        rd_chk(9'h020, 32'h01, 1'b0);
        @(posedge pclk);
        stat_in <= 4'hA;
        wr(9'h024, 8'hF5);
        wr(9'h028, 8'hFF);
        rd_chk(9'h024, 32'h0A, 1'b0);
        rd_chk(9'h028, {24'h0, REV_TB}, 1'b0);
        // unmapped and misaligned places answer with an error
        wr(9'h02C, 8'h55);
        rd_chk(9'h02C, 32'h0, 1'b1);
        rd_chk(9'h161, 32'h0, 1'b1);
        // write then read with no idle cycle between them
        apb(1'b1, A_DLY, 8'hFE, 1'b1, rd_v, er_v);
        apb(1'b0, A_DLY, 8'h00, 1'b0, rd_v, er_v);
        chk("b2b_delay", rd_v, 32'h0E);
        rd_chk(A_DLY, 32'h0E, 1'b0);
        end_sim();
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge pclk);
        err_total++;
        end_sim();
    end
endmodule // modulator_delay_chop_config_tb_top
`default_nettype wire
